//--- pswc_consts.svh
// constants for the power state wake controller
`ifndef PSWC_CONSTS_SVH
`define PSWC_CONSTS_SVH
`define PSWC_ADDR_PMC        8'h54
`define PSWC_ADDR_WAKE_TEST  8'h64
`define PSWC_ADDR_INTERRUPT_STATUS_REG    8'h58
`define PSWC_ADDR_INT_EN     8'h5C
`define PSWC_ADDR_PHY_CTRL   8'h60
`define PSWC_MODE_NORMAL     2'h0
`define PSWC_MODE_WOL        2'h1
`define PSWC_MODE_ENERGY     2'h2
`define PSWC_SRC_NONE        2'h0
`define PSWC_SRC_ENERGY      2'h1
`define PSWC_SRC_FRAME       2'h2
`define PSWC_PMC_MODE_LO     12
`define PSWC_PMC_MODE_HI     13
`define PSWC_PMC_SRC_LO      14
`define PSWC_PMC_SRC_HI      15
`define PSWC_PMC_ENERGY_EN   2
`define PSWC_PMC_FRAME_EN    1
`define PSWC_PMC_PIN_EN      3
`define PSWC_PMC_PULSE_SEL   4
`define PSWC_PMC_READY       0
`define PSWC_INT_WAKE        0
`define PSWC_INT_ENERGY      1
`define PSWC_PHY_PWRDN       0
`define PSWC_PHY_EDPD        1
`define PSWC_CLK_MHZ         100
`define PSWC_PULSE_MS        50
`define PSWC_READY_MS        2
`define PSWC_PULSE_CYC       (`PSWC_PULSE_MS * 1000 * `PSWC_CLK_MHZ)
`define PSWC_READY_DELAY_CYC 1000
`endif

//--- pswc_pkg.sv
// types for the power state wake controller
package pswc_pkg;
    typedef enum logic [1:0] {
        PSWC_NORMAL = 2'b00,
        PSWC_WOL    = 2'b01,
        PSWC_ENERGY = 2'b10,
        PSWC_WAKING = 2'b11
    } pswc_state_e;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pswc_bus_s;
    typedef struct packed {
        logic mac_clk_en;
        logic host_clk_en;
        logic rx_pm_clk_en;
        logic int_clk_en;
        logic phy_clk_en;
    } pswc_gate_s;
endpackage

//--- pswc_ctrl.sv
// power state and wake event controller
//
// Behaviour
// - one normal, two sleep states; 01 selects wol
// - wol sleep keeps phy, rx pm clocks
// - sleep entry clears ready; pmc only readable
// - wake-test write returns to normal state
// - wol sleep: frame detect sets source 10
// - energy sleep: carrier sets source 01
// - pin needs pin enable and source enable
// - wake status set regardless of pin enable
// - status sticks while internal wake active
// - pulse mode drives pin for 50ms
// - static mode holds pin until deactivated
// - pin released on source/enable clear
// - phy power-down bit holds phy down
// - edpd with no energy powers phy down
// - energy raises flag and phy powers up
// - early packets may drop on power-up
// - energy sleep gates all clocks, edpd
// - configuration retained through sleep
// - ready set within 2ms of wake write
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "pswc_consts.svh"
module pswc_ctrl (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire pswc_pkg::pswc_bus_s  bus,
    output logic [31:0]               rdata,
    input  wire logic                 wake_frame_det,
    input  wire logic                 magic_pkt_det,
    input  wire logic                 line_energy_raw,
    output logic                      wake_event_pin,
    output logic                      host_irq,
    output pswc_pkg::pswc_gate_s      gates,
    output logic                      phy_powered,
    output logic                      phy_reset_pulse
);
    import pswc_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [2:0] sync1;
    logic [2:0] sync2;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {line_energy_raw, magic_pkt_det, wake_frame_det};
            sync2 <= sync1;
        end
    end
    logic frame_hit;
    logic line_energy_present;
    assign frame_hit           = sync2[0] | sync2[1];
    assign line_energy_present = sync2[2];

    // ****************************************
    // state and registers
    // ****************************************
    pswc_state_e state;
    logic [1:0]  power_state_select;
    logic [1:0]  wake_source_status;
    logic        ready;
    logic        wake_frame_enable;
    logic        energy_wake_enable;
    logic        wake_pin_enable;
    logic        wake_pin_pulse_select;
    logic        wake_int_status;
    logic        energy_on_flag;
    logic [1:0]  int_enable;
    logic        phy_pwrdn;
    logic        energy_powerdown_enable;
    logic        read_seen;
    logic [20:0] ready_cnt;

    logic asleep;
    logic wr_ok;
    logic wake_wr;
    assign asleep  = (state == PSWC_WOL) || (state == PSWC_ENERGY);
    assign wake_wr = bus.wr && (bus.addr == `PSWC_ADDR_WAKE_TEST) && asleep;
    assign wr_ok   = bus.wr && read_seen && ready && !asleep;

    // first read after reset or wake arms writes
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            read_seen <= 1'b0;
        end else if (wake_wr || (state == PSWC_WAKING)) begin
            read_seen <= 1'b0;
        end else if (bus.rd) begin
            read_seen <= 1'b1;
        end
    end

    // power state sequencing
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state              <= PSWC_NORMAL;
            power_state_select <= `PSWC_MODE_NORMAL;
            ready              <= 1'b1;
            ready_cnt          <= 21'h0;
        end else begin
            unique case (state)
                PSWC_NORMAL: begin
                    if (wr_ok && bus.addr == `PSWC_ADDR_PMC) begin
                        power_state_select <= bus.wdata[`PSWC_PMC_MODE_HI:`PSWC_PMC_MODE_LO];
                        if (bus.wdata[`PSWC_PMC_MODE_HI:`PSWC_PMC_MODE_LO] == `PSWC_MODE_WOL) begin
                            state <= PSWC_WOL;
                            ready <= 1'b0;
                        end else if (bus.wdata[`PSWC_PMC_MODE_HI:`PSWC_PMC_MODE_LO] == `PSWC_MODE_ENERGY) begin
                            state <= PSWC_ENERGY;
                            ready <= 1'b0;
                        end
                    end
                end
                PSWC_WOL, PSWC_ENERGY: begin
                    if (wake_wr) begin
                        state              <= PSWC_WAKING;
                        power_state_select <= `PSWC_MODE_NORMAL;
                        ready_cnt          <= 21'h0;
                    end
                end
                PSWC_WAKING: begin
                    if (ready_cnt == 21'(`PSWC_READY_DELAY_CYC)) begin
                        state <= PSWC_NORMAL;
                        ready <= 1'b1;
                    end else begin
                        ready_cnt <= ready_cnt + 21'h1;
                    end
                end
            endcase
        end
    end

    // clock gating per state
    always_comb begin
        gates.phy_clk_en   = (state != PSWC_ENERGY);
        gates.rx_pm_clk_en = (state != PSWC_ENERGY);
        gates.int_clk_en   = (state != PSWC_ENERGY);
        gates.mac_clk_en   = !asleep;
        gates.host_clk_en  = !asleep;
    end

    // ****************************************
    // configuration (retained in sleep)
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_frame_enable       <= 1'b0;
            energy_wake_enable      <= 1'b0;
            wake_pin_enable         <= 1'b0;
            wake_pin_pulse_select   <= 1'b0;
            int_enable              <= 2'h0;
            phy_pwrdn               <= 1'b0;
            energy_powerdown_enable <= 1'b0;
        end else if (wr_ok) begin
            if (bus.addr == `PSWC_ADDR_PMC) begin
                wake_frame_enable     <= bus.wdata[`PSWC_PMC_FRAME_EN];
                energy_wake_enable    <= bus.wdata[`PSWC_PMC_ENERGY_EN];
                wake_pin_enable       <= bus.wdata[`PSWC_PMC_PIN_EN];
                wake_pin_pulse_select <= bus.wdata[`PSWC_PMC_PULSE_SEL];
            end
            if (bus.addr == `PSWC_ADDR_INT_EN) begin
                int_enable <= bus.wdata[1:0];
            end
            if (bus.addr == `PSWC_ADDR_PHY_CTRL) begin
                phy_pwrdn               <= bus.wdata[`PSWC_PHY_PWRDN];
                energy_powerdown_enable <= bus.wdata[`PSWC_PHY_EDPD];
            end
        end
    end

    // ****************************************
    // wake detection
    // ****************************************
    logic frame_evt;
    logic energy_evt;
    logic internal_wake_interrupt;
    assign frame_evt  = (state == PSWC_WOL) && frame_hit;
    assign energy_evt = (state == PSWC_ENERGY) && line_energy_present;
    assign internal_wake_interrupt =
        (wake_source_status == `PSWC_SRC_FRAME && wake_frame_enable) ||
        (wake_source_status == `PSWC_SRC_ENERGY && energy_wake_enable);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_source_status <= `PSWC_SRC_NONE;
        end else if (frame_evt) begin
            wake_source_status <= `PSWC_SRC_FRAME;
        end else if (energy_evt) begin
            wake_source_status <= `PSWC_SRC_ENERGY;
        end else if (wr_ok && bus.addr == `PSWC_ADDR_PMC) begin
            wake_source_status <= bus.wdata[`PSWC_PMC_SRC_HI:`PSWC_PMC_SRC_LO] & wake_source_status;
        end
    end

    // wake interrupt status, write one to clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_int_status <= 1'b0;
        end else if (internal_wake_interrupt) begin
            wake_int_status <= 1'b1;
        end else if (wr_ok && bus.addr == `PSWC_ADDR_INTERRUPT_STATUS_REG && bus.wdata[`PSWC_INT_WAKE]) begin
            wake_int_status <= 1'b0;
        end
    end

    // phy energy flag, set wins over clear
    logic energy_prev;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            energy_prev    <= 1'b0;
            energy_on_flag <= 1'b0;
        end else begin
            energy_prev <= line_energy_present;
            if (line_energy_present && !energy_prev && energy_powerdown_enable) begin
                energy_on_flag <= 1'b1;
            end else if (wr_ok && bus.addr == `PSWC_ADDR_INTERRUPT_STATUS_REG && bus.wdata[`PSWC_INT_ENERGY]) begin
                energy_on_flag <= 1'b0;
            end
        end
    end

    assign host_irq = (wake_int_status && int_enable[`PSWC_INT_WAKE]) ||
                      (energy_on_flag && int_enable[`PSWC_INT_ENERGY]);

    // phy power: general power-down and energy-detect power-down
    always_comb begin
        phy_powered = !phy_pwrdn && !(energy_powerdown_enable && !line_energy_present);
    end
    logic pwrdn_prev;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwrdn_prev      <= 1'b0;
            phy_reset_pulse <= 1'b0;
        end else begin
            pwrdn_prev      <= phy_pwrdn;
            phy_reset_pulse <= pwrdn_prev && !phy_pwrdn;
        end
    end

    // ****************************************
    // wake event pin
    // ****************************************
    logic        pin_qual;
    logic        pin_active;
    logic [22:0] pulse_cnt;
    logic        new_evt;
    assign pin_qual = wake_pin_enable && internal_wake_interrupt;
    assign new_evt  = frame_evt || energy_evt;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_active <= 1'b0;
            pulse_cnt  <= 23'h0;
        end else if (!pin_qual) begin
            pin_active <= 1'b0;
            pulse_cnt  <= 23'h0;
        end else if (new_evt && !pin_active && pulse_cnt == 23'h0) begin
            pin_active <= 1'b1;
            pulse_cnt  <= 23'h1;
        end else if (pin_active && wake_pin_pulse_select) begin
            if (pulse_cnt == 23'(`PSWC_PULSE_CYC)) begin
                pin_active <= 1'b0;
            end else begin
                pulse_cnt <= pulse_cnt + 23'h1;
            end
        end
    end
    assign wake_event_pin = pin_active;

    // ****************************************
    // register read port
    // ****************************************
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0;
        if (bus.rd) begin
            if (bus.addr == `PSWC_ADDR_PMC) begin
                next_rdata[`PSWC_PMC_MODE_HI:`PSWC_PMC_MODE_LO] = power_state_select;
                next_rdata[`PSWC_PMC_SRC_HI:`PSWC_PMC_SRC_LO]   = wake_source_status;
                next_rdata[`PSWC_PMC_READY]     = ready;
                next_rdata[`PSWC_PMC_FRAME_EN]  = wake_frame_enable;
                next_rdata[`PSWC_PMC_ENERGY_EN] = energy_wake_enable;
                next_rdata[`PSWC_PMC_PIN_EN]    = wake_pin_enable;
                next_rdata[`PSWC_PMC_PULSE_SEL] = wake_pin_pulse_select;
            end else if (!asleep) begin
                if (bus.addr == `PSWC_ADDR_INTERRUPT_STATUS_REG) begin
                    next_rdata[`PSWC_INT_WAKE]   = wake_int_status;
                    next_rdata[`PSWC_INT_ENERGY] = energy_on_flag;
                end else if (bus.addr == `PSWC_ADDR_INT_EN) begin
                    next_rdata[1:0] = int_enable;
                end else if (bus.addr == `PSWC_ADDR_PHY_CTRL) begin
                    next_rdata[`PSWC_PHY_PWRDN] = phy_pwrdn;
                    next_rdata[`PSWC_PHY_EDPD]  = energy_powerdown_enable;
                end
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_sleep_ready: assert property (@(posedge core_clk) disable iff (!rst_b)
        asleep |-> !ready) else $error("ready set while asleep");
    chk_wake_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        wake_wr |=> (state == PSWC_WAKING) && (power_state_select == `PSWC_MODE_NORMAL))
        else $error("wake write did not wake");
    chk_frame_src: assert property (@(posedge core_clk) disable iff (!rst_b)
        frame_evt |=> wake_source_status == `PSWC_SRC_FRAME) else $error("frame source wrong");
    chk_energy_src: assert property (@(posedge core_clk) disable iff (!rst_b)
        (energy_evt && !frame_evt) |=> wake_source_status == `PSWC_SRC_ENERGY)
        else $error("energy source wrong");
    chk_pin_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        wake_event_pin |-> $past(wake_pin_enable)) else $error("pin without enable");
    chk_int_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(internal_wake_interrupt) |-> wake_int_status) else $error("status dropped");
    chk_pin_release: assert property (@(posedge core_clk) disable iff (!rst_b)
        !pin_qual |=> !wake_event_pin) else $error("pin not released");

    // cycles since the wake write, for the ready deadline
    logic [10:0] wake_wait;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_wait <= 11'h000;
        end else if (wake_wr) begin
            wake_wait <= 11'h001;
        end else if (ready) begin
            wake_wait <= 11'h000;
        end else if (wake_wait != 11'h000) begin
            wake_wait <= wake_wait + 11'h001;
        end
    end
    chk_ready_time: assert property (@(posedge core_clk) disable iff (!rst_b)
        wake_wait <= 11'(`PSWC_READY_DELAY_CYC + 2)) else $error("ready late");
    chk_wol_clocks: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state == PSWC_WOL) |-> gates.phy_clk_en && gates.rx_pm_clk_en && !gates.mac_clk_en)
        else $error("wol clocks wrong");
    chk_energy_clocks: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state == PSWC_ENERGY) |-> !gates.int_clk_en && !gates.host_clk_en)
        else $error("energy clocks wrong");
    chk_write_locked: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus.wr && !read_seen && state == PSWC_NORMAL) |=> $stable(wake_frame_enable) && $stable(int_enable))
        else $error("write before read took effect");
    chk_sleep_reads: assert property (@(posedge core_clk) disable iff (!rst_b)
        (bus.rd && asleep && bus.addr != `PSWC_ADDR_PMC) |=> (rdata == 32'h0))
        else $error("register readable while asleep");
    chk_energy_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        (line_energy_present && !energy_prev && energy_powerdown_enable) |=> energy_on_flag)
        else $error("energy flag not set");
    chk_phy_restart: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($past(phy_pwrdn) && !phy_pwrdn) |=> phy_reset_pulse) else $error("phy not reset on power up");
    chk_edpd_down: assert property (@(posedge core_clk) disable iff (!rst_b)
        (energy_powerdown_enable && !line_energy_present) |-> !phy_powered) else $error("phy powered without energy");
    chk_static_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wake_event_pin && !wake_pin_pulse_select && pin_qual) |=> wake_event_pin) else $error("static pin dropped");
    chk_pulse_end: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wake_event_pin && wake_pin_pulse_select && pulse_cnt == 23'(`PSWC_PULSE_CYC)) |=> !wake_event_pin)
        else $error("pulse too long");
endmodule

//--- pswc_line_model.sv
// line side model: wake frame, magic packet and line energy sources
`timescale 1ns/1ns
// ****************************************
// line model
// ****************************************
module pswc_line_model (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic frame_req,
    input  wire logic magic_req,
    input  wire logic energy_req,
    output logic      wake_frame_det,
    output logic      magic_pkt_det,
    output logic      line_energy_raw
);
    logic [2:0] frame_cnt;
    logic [2:0] magic_cnt;
    // detections stretched so the synchroniser sees them
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_cnt <= 3'h0;
            magic_cnt <= 3'h0;
        end else begin
            frame_cnt <= frame_req ? 3'h4 : (frame_cnt != 3'h0 ? frame_cnt - 3'h1 : 3'h0);
            magic_cnt <= magic_req ? 3'h4 : (magic_cnt != 3'h0 ? magic_cnt - 3'h1 : 3'h0);
        end
    end
    assign wake_frame_det = (frame_cnt != 3'h0);
    assign magic_pkt_det  = (magic_cnt != 3'h0);
    // line energy follows the far end level
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            line_energy_raw <= 1'b0;
        end else begin
            line_energy_raw <= energy_req;
        end
    end
endmodule

//--- power_state_wake_controller_tb.sv
// testbench for the power state wake controller
`timescale 1ns/1ns
`include "pswc_consts.svh"
module power_state_wake_controller_tb;
    import pswc_pkg::*;
    logic        core_clk;
    logic        rst_b;
    pswc_bus_s   bus;
    logic [31:0] rdata;
    logic        wake_frame_det;
    logic        magic_pkt_det;
    logic        line_energy_raw;
    logic        wake_event_pin;
    logic        host_irq;
    pswc_gate_s  gates;
    logic        phy_powered;
    logic        phy_reset_pulse;
    logic        frame_req;
    logic        magic_req;
    logic        energy_req;
    logic        rst_seen;
    int          err_count;
    int          compares;
    int          cycles;
    // ****************************************
    // instances
    // ****************************************
    pswc_ctrl uut (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .wake_frame_det(wake_frame_det), .magic_pkt_det(magic_pkt_det), .line_energy_raw(line_energy_raw),
        .wake_event_pin(wake_event_pin), .host_irq(host_irq), .gates(gates), .phy_powered(phy_powered),
        .phy_reset_pulse(phy_reset_pulse));
    pswc_line_model line (.core_clk(core_clk), .rst_b(rst_b), .frame_req(frame_req), .magic_req(magic_req),
        .energy_req(energy_req), .wake_frame_det(wake_frame_det), .magic_pkt_det(magic_pkt_det),
        .line_energy_raw(line_energy_raw));
    // ****************************************
    // clock, timeout, monitors
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (phy_reset_pulse === 1'b1) begin
            rst_seen <= 1'b1;
        end
        if (cycles == 30000) begin
            err_count = err_count + 1;
            end_sim();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_bit(input string name, input logic got, input logic exp);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge core_clk);
        bus.wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge core_clk);
        bus.rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] v;
        rd(a, v);
        chk_word(name, exp, v);
    endtask
    task automatic wake();
        logic [31:0] v;
        int          n;
        v = 32'h0;
        n = 0;
        wr(`PSWC_ADDR_WAKE_TEST, 32'hFFFF0000);
        while (v[0] !== 1'b1 && n < 800) begin
            rd(`PSWC_ADDR_PMC, v);
            n = n + 1;
        end
        chk_bit("ready after wake", v[0], 1'b1);
    endtask
    task automatic wol_round(input int kind);
        wr(`PSWC_ADDR_PMC, 32'h0000100A);
        rd_chk(`PSWC_ADDR_PMC, 32'h0000100A, "pmc wol asleep");
        chk_bit("mac clk wol", gates.mac_clk_en, 1'b0);
        chk_bit("host clk wol", gates.host_clk_en, 1'b0);
        chk_bit("rx pm clk wol", gates.rx_pm_clk_en, 1'b1);
        chk_bit("phy clk wol", gates.phy_clk_en, 1'b1);
        rd_chk(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000000, "status hidden");
        chk_bit("pin before event", wake_event_pin, 1'b0);
        if (kind == 0) begin
            frame_req <= 1'b1;
        end else begin
            magic_req <= 1'b1;
        end
        @(posedge core_clk);
        frame_req <= 1'b0;
        magic_req <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd_chk(`PSWC_ADDR_PMC, 32'h0000900A, "pmc frame source");
        chk_bit("pin static", wake_event_pin, 1'b1);
        chk_bit("irq wake", host_irq, 1'b1);
        wake();
        rd_chk(`PSWC_ADDR_PMC, 32'h0000800B, "pmc after wake");
        rd_chk(`PSWC_ADDR_INT_EN, 32'h00000001, "enable kept");
        chk_bit("pin held", wake_event_pin, 1'b1);
        wr(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000001);
        rd_chk(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000001, "status sticky");
        wr(`PSWC_ADDR_PMC, 32'h0000000A);
        rd_chk(`PSWC_ADDR_PMC, 32'h0000000B, "source cleared");
        chk_bit("pin released", wake_event_pin, 1'b0);
        wr(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000001);
        rd_chk(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000000, "status cleared");
        chk_bit("irq cleared", host_irq, 1'b0);
        $display("test wol round %0d done", kind);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_b = 1'b0;
        bus = '0;
        frame_req = 1'b0;
        magic_req = 1'b0;
        energy_req = 1'b0;
        rst_seen = 1'b0;
        err_count = 0;
        compares = 0;
        cycles = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        wr(`PSWC_ADDR_INT_EN, 32'h00000003);
        rd_chk(`PSWC_ADDR_PMC, 32'h00000001, "pmc reset");
        rd_chk(`PSWC_ADDR_INT_EN, 32'h00000000, "early write");
        wr(`PSWC_ADDR_INT_EN, 32'h00000001);
        rd_chk(`PSWC_ADDR_INT_EN, 32'h00000001, "enable write");
        rd_chk(`PSWC_ADDR_PHY_CTRL, 32'h00000000, "phy reset");
        rd_chk(8'h40, 32'h00000000, "unmapped");
        $display("test reset and first read done");
        for (int k = 0; k < 2; k++) begin
            wol_round(k);
        end
        energy_req <= 1'b1;
        wr(`PSWC_ADDR_PHY_CTRL, 32'h00000002);
        wr(`PSWC_ADDR_PMC, 32'h0000201C);
        repeat (8) @(posedge core_clk);
        rd_chk(`PSWC_ADDR_PMC, 32'h0000601C, "pmc energy source");
        chk_bit("pin pulse", wake_event_pin, 1'b1);
        chk_bit("mac clk energy", gates.mac_clk_en, 1'b0);
        chk_bit("host clk energy", gates.host_clk_en, 1'b0);
        chk_bit("int clk energy", gates.int_clk_en, 1'b0);
        wake();
        rd_chk(`PSWC_ADDR_PMC, 32'h0000401D, "pmc energy wake");
        chk_bit("pulse running", wake_event_pin, 1'b1);
        wr(`PSWC_ADDR_PHY_CTRL, 32'h00000000);
        wr(`PSWC_ADDR_PMC, 32'h00000018);
        rd_chk(`PSWC_ADDR_PMC, 32'h00000019, "energy enable off");
        chk_bit("pulse cut", wake_event_pin, 1'b0);
        wr(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000003);
        rd_chk(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000000, "status cleared energy");
        $display("test energy sleep done");
        wr(`PSWC_ADDR_PHY_CTRL, 32'h00000002);
        energy_req <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk_bit("edpd no energy", phy_powered, 1'b0);
        energy_req <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk_bit("edpd energy", phy_powered, 1'b1);
        rd_chk(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000002, "energy flag");
        wr(`PSWC_ADDR_INTERRUPT_STATUS_REG, 32'h00000002);
        wr(`PSWC_ADDR_PHY_CTRL, 32'h00000001);
        repeat (2) @(posedge core_clk);
        chk_bit("general power down", phy_powered, 1'b0);
        rst_seen <= 1'b0;
        wr(`PSWC_ADDR_PHY_CTRL, 32'h00000000);
        repeat (3) @(posedge core_clk);
        chk_bit("phy powered up", phy_powered, 1'b1);
        chk_bit("phy reset pulse", rst_seen, 1'b1);
        $display("test phy power down done");
        end_sim();
    end
endmodule
